/* inc/aths_pkg.sv */
// Shared constants and types for the track/hold sequencer of a serial SAR converter.
// Assumes a 250 MHz system clock and a slave-side two-wire bus clocked by the master.
package aths_pkg;

  // Conversion geometry.
  localparam int          CONV_BITS     = 10;
  localparam int          BYTE_BITS     = 8;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [3:0]  BIT_ACK_DRIVE = 4'h8;
  localparam logic [3:0]  BIT_ACK_END   = 4'h9;
  localparam logic [3:0]  BIT_ACK_DONE  = 4'hA;
  localparam logic [3:0]  BIT_HOLD_EXT  = 4'h1;

  // Setup byte layout, marked by a set most significant bit.
  localparam int          BYTE_MARK_BIT = 7;
  localparam int          SETUP_SEL1    = 5;
  localparam int          SETUP_CLK_BIT = 3;
  localparam int          SETUP_BIP_BIT = 2;
  localparam int          SETUP_RST_BIT = 1;
  localparam logic [7:0]  SETUP_RST_VAL = 8'h82;

  // Configuration byte layout.
  localparam int          CFG_CS_HI     = 4;
  localparam int          CFG_CS_LO     = 1;
  localparam int          CFG_PAIR_BIT  = 0;
  localparam logic [7:0]  CFG_RST_VAL   = 8'h01;

  // Padding that fills the upper bits of the first result byte.
  localparam logic [5:0]  RESULT_PAD    = 6'h3F;

  // Internal conversion clock, derived from the system clock.
  localparam int          SYS_CLK_PERIOD_NS  = 4;
  localparam int          INT_CONV_PERIOD_NS = 400;
  localparam int          INT_CONV_DIV =
    (INT_CONV_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // Bus sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_CONV_INT, ST_RD_BYTE, ST_RD_ACK
  } aths_state_type;

endpackage

/* core/aths_sync.sv */
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a slow level or a toggle; multi-bit words must not pass here.
`timescale 1ns/1ps
module aths_sync #(
  parameter int WIDTH = 1
) (
  // Clock, reset and enable.
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             en,
  // Levels in and out.
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  // The first stage feeds only the second, so metastability settles before use.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= '0;
      syncOut  <= '0;
    end else if (en) begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule

/* core/aths_sar_engine.sv */
// Successive-approximation register: one result bit decided per step pulse.
// Assumes the comparator answer is valid when a step arrives for the current trial code.
`timescale 1ns/1ps
module aths_sar_engine
  import aths_pkg::*;
#(
  parameter int BITS = CONV_BITS
) (
  // Clock, reset and enable.
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            en,
  // Control.
  input  wire logic            start,
  input  wire logic            step,
  input  wire logic            compHigh,
  // Results.
  output logic      [BITS-1:0] code,
  output logic                 busy,
  output logic                 done
);

  logic [BITS-1:0] trialBit_r;
  wire  [BITS-1:0] keepMask = compHigh ? code : (code & ~trialBit_r);
  wire  [BITS-1:0] nextTrial = trialBit_r >> 1;
  wire             lastStep = trialBit_r[0];

  initial begin
    if (BITS < 2) $error("aths_sar_engine needs at least two bits");
  end

  // A start loads mid-scale; each step fixes one bit and trials the next, BITS steps in all.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code       <= '0;
      trialBit_r <= '0;
      busy       <= 1'b0;
      done       <= 1'b0;
    end else if (en) begin
      done <= 1'b0;
      if (start) begin
        trialBit_r <= {1'b1, {(BITS-1){1'b0}}};
        code       <= {1'b1, {(BITS-1){1'b0}}};
        busy       <= 1'b1;
      end else if (busy && step) begin
        code       <= keepMask | nextTrial; // R01
        trialBit_r <= nextTrial;
        busy       <= !lastStep;
        done       <= lastStep;
      end
    end
  end

endmodule

/* core/aths_sequencer.sv */
// Track/hold and conversion sequencer of a multichannel SAR converter on a two-wire bus.
// Assumes bus pins are open drain with pull-ups outside, and the master also drives sclClk.
`timescale 1ns/1ps

// Notes on behaviour
// R01 - Every conversion takes exactly ten conversion clock cycles, one result bit each.
// R02 - With the internal clock, tracking starts on the eighth rising SCL edge of the address.
// R03 - With the internal clock, hold starts on the falling SCL edge of the ninth pulse.
// R04 - With the internal clock, SCL is held low while conversions run; the master waits.
// R05 - With the external clock, a matching read address starts tracking on the R/W rising edge.
// R06 - With the external clock, hold starts on the second rising edge of the first result byte.
// R07 - With the external clock, the next ten SCL cycles clock the conversion; the master keeps clocking.
// R08 - Tracking lasts 1.5 SCL periods internally clocked and 3 SCL periods externally clocked.
// R09 - Single-ended mode routes the selected input against ground to the sampling capacitor.
// R10 - Differential mode routes the selected positive and negative pair to the capacitor.
// R11 - The shared pin acts as analog input 3 or as reference, chosen by a setup setting.
// R12 - The input pairing bit selects single-ended when 1 and differential when 0.
// R13 - A written byte with its top bit set is the setup byte, otherwise the configuration byte.
// R14 - A matching address byte is acknowledged by pulling SDA low for one clock cycle.
// R15 - The setup clock bit picks internal or external clocking; SCL is released once data is ready.
// R16 - The sample stage stays in hold for the whole conversion.
module aths_sequencer
  import aths_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h55, // Arbitrary value.
  parameter int         NUM_CH   = 12,
  parameter int         CONV_DIV = INT_CONV_DIV
) (
  // System clock, reset and enable.
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  // Link clock, the bus clock line used as a clock.
  input  wire logic        sclClk,
  // Bus clock pin, open drain.
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  // Bus data pin, open drain.
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Analog front end.
  input  wire logic        compHigh,
  output logic [9:0]       dacCode,
  output logic             trackOn,
  output logic [3:0]       muxPos,
  output logic [3:0]       muxNeg,
  output logic             negToGnd,
  output logic             sharedPinIsRef,
  // Status.
  output logic             convBusy,
  output logic [9:0]       resultData,
  output logic             extClkMode,
  output logic             bipolar
);

  initial begin
    if (NUM_CH < 1 || NUM_CH > 16) $error("aths_sequencer supports 1 to 16 channels");
    if (CONV_DIV < 1 || CONV_DIV > 65536) $error("aths_sequencer divider out of range");
  end

  // Synchronised pins and the step toggle returning from the link domain.
  logic       sclS;
  logic       sdaS;
  logic       compS;
  logic       stepTglS;
  logic       armLink;
  logic       stepTgl_r;
  logic       sclPrev_r;
  logic       sdaPrev_r;
  logic       stepTglPrev_r;

  aths_sync #(.WIDTH(4)) u_sys_sync (
    .clk     (sys_clk),
    .rst_n   (reset_n),
    .en      (clkEn),
    .asyncIn ({sclIn, sdaIn, compHigh, stepTgl_r}),
    .syncOut ({sclS, sdaS, compS, stepTglS})
  );

  // Sequencer state.
  aths_state_type state_r;
  aths_state_type state_nxt;
  logic [3:0]     bitCnt_r;
  logic [3:0]     bitCnt_nxt;
  logic [7:0]     shift_r;
  logic [7:0]     shift_nxt;
  logic [7:0]     setup_r;
  logic [7:0]     setup_nxt;
  logic [7:0]     cfg_r;
  logic [7:0]     cfg_nxt;
  logic           isRead_r;
  logic           isRead_nxt;
  logic           byteIdx_r;
  logic           byteIdx_nxt;
  logic           sdaOe_r;
  logic           sdaOe_nxt;
  logic           sclOe_r;
  logic           sclOe_nxt;
  logic           track_r;
  logic           track_nxt;
  logic           armExt_r;
  logic           armExt_nxt;
  logic           convInt_r;
  logic           convInt_nxt;
  logic           engStart;
  logic [15:0]    divCnt_r;
  logic [9:0]     engCode;
  logic           engBusy;
  logic           engDone;

  // Bus events seen in the system domain.
  wire sclRise   = sclS && !sclPrev_r;
  wire sclFall   = !sclS && sclPrev_r;
  wire busStart  = sclS && sclPrev_r && sdaPrev_r && !sdaS;
  wire busStop   = sclS && sclPrev_r && !sdaPrev_r && sdaS;
  wire [7:0] rxByte = {shift_r[6:0], sdaS};
  wire addrMatch = (shift_r[6:0] == DEV_ADDR);
  wire useExt    = setup_r[SETUP_CLK_BIT]; // R15
  wire isSetup   = rxByte[BYTE_MARK_BIT]; // R13
  // Bytes after the first come from the stored result: a bus-clocked conversion
  // rewrites the engine code while the earlier pair is still being shifted out.
  wire [7:0] firstByte  = {RESULT_PAD, engCode[9:8]};
  wire [7:0] heldFirst  = {RESULT_PAD, resultData[9:8]};
  wire [7:0] secondByte = resultData[7:0];
  wire [7:0] nextRdByte = byteIdx_r ? heldFirst : secondByte;
  wire divWrap   = (divCnt_r == 16'(CONV_DIV - 1));

  // Conversion steps: internal divider, or SCL rising edges via the link toggle.
  wire intStep = convInt_r && divWrap;
  wire extStep = armExt_r && (stepTglS != stepTglPrev_r); // R07
  wire engStep = useExt ? extStep : intStep;

  // Input routing from the configuration byte.
  wire       singleEnded = cfg_r[CFG_PAIR_BIT]; // R12
  wire [3:0] chSel       = cfg_r[CFG_CS_HI:CFG_CS_LO];
  wire [3:0] posSel      = singleEnded ? chSel : {chSel[3:1], 1'b0};
  wire [3:0] negSel      = singleEnded ? 4'h0 : {chSel[3:1], 1'b1};

  aths_sar_engine #(.BITS(CONV_BITS)) u_engine (
    .clk      (sys_clk),
    .rst_n    (reset_n),
    .en       (clkEn),
    .start    (engStart),
    .step     (engStep),
    .compHigh (compS),
    .code     (engCode),
    .busy     (engBusy),
    .done     (engDone)
  );

  // Link domain: every SCL rise while armed advances the conversion by one step.
  aths_sync #(.WIDTH(1)) u_link_sync (
    .clk     (sclClk),
    .rst_n   (reset_n),
    .en      (1'b1),
    .asyncIn (armExt_r),
    .syncOut (armLink)
  );

  always_ff @(posedge sclClk or negedge reset_n) begin
    if (!reset_n) begin
      stepTgl_r <= 1'b0;
    end else if (armLink) begin
      stepTgl_r <= !stepTgl_r; // R07
    end
  end

  // Next-state logic of the bus sequencer.
  always_comb begin
    state_nxt   = state_r;
    bitCnt_nxt  = bitCnt_r;
    shift_nxt   = shift_r;
    setup_nxt   = setup_r;
    cfg_nxt     = cfg_r;
    isRead_nxt  = isRead_r;
    byteIdx_nxt = byteIdx_r;
    sdaOe_nxt   = sdaOe_r;
    sclOe_nxt   = sclOe_r;
    track_nxt   = track_r;
    armExt_nxt  = armExt_r;
    convInt_nxt = convInt_r;
    engStart    = 1'b0;
    if (busStop) begin
      state_nxt   = ST_IDLE;
      sdaOe_nxt   = 1'b0;
      sclOe_nxt   = 1'b0;
    end else if (busStart) begin
      state_nxt  = ST_ADDR;
      bitCnt_nxt = 4'h0;
      sdaOe_nxt  = 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
        end
        ST_ADDR: if (sclRise) begin
          shift_nxt  = rxByte;
          bitCnt_nxt = bitCnt_r + 4'h1;
          if (bitCnt_r == BIT_LAST) begin
            isRead_nxt = sdaS;
            state_nxt  = addrMatch ? ST_ADDR_ACK : ST_IDLE;
            if (addrMatch && sdaS && !engBusy) begin
              track_nxt = 1'b1; // R02 R05 R08
            end
          end
        end
        ST_ADDR_ACK: if (sclFall && bitCnt_r == BIT_ACK_DRIVE) begin
          sdaOe_nxt  = 1'b1; // R14
          bitCnt_nxt = BIT_ACK_END;
        end else if (sclFall && bitCnt_r == BIT_ACK_END) begin
          sdaOe_nxt   = 1'b0;
          bitCnt_nxt  = 4'h0;
          byteIdx_nxt = 1'b0;
          if (!isRead_r) begin
            state_nxt = ST_WR_BYTE;
          end else if (!useExt) begin
            track_nxt   = 1'b0; // R03
            engStart    = 1'b1;
            sclOe_nxt   = 1'b1; // R04
            convInt_nxt = 1'b1;
            state_nxt   = ST_CONV_INT;
          end else begin
            shift_nxt = heldFirst;
            sdaOe_nxt = !heldFirst[7];
            state_nxt = ST_RD_BYTE;
          end
        end
        ST_WR_BYTE: if (sclRise) begin
          shift_nxt  = rxByte;
          bitCnt_nxt = bitCnt_r + 4'h1;
          if (bitCnt_r == BIT_LAST) begin
            state_nxt = ST_WR_ACK;
            if (isSetup) begin
              setup_nxt = rxByte; // R13
              if (!rxByte[SETUP_RST_BIT]) begin
                cfg_nxt = CFG_RST_VAL;
              end
            end else begin
              cfg_nxt = rxByte; // R13
            end
          end
        end
        ST_WR_ACK: if (sclFall && bitCnt_r == BIT_ACK_DRIVE) begin
          sdaOe_nxt  = 1'b1;
          bitCnt_nxt = BIT_ACK_END;
        end else if (sclFall && bitCnt_r == BIT_ACK_END) begin
          sdaOe_nxt  = 1'b0;
          bitCnt_nxt = 4'h0;
          state_nxt  = ST_WR_BYTE;
        end
        ST_CONV_INT: if (engDone) begin
          convInt_nxt = 1'b0;
          sclOe_nxt   = 1'b0; // R15
          shift_nxt   = firstByte;
          sdaOe_nxt   = !firstByte[7];
          state_nxt   = ST_RD_BYTE;
        end
        ST_RD_BYTE: if (sclRise) begin
          bitCnt_nxt = bitCnt_r + 4'h1;
          if (useExt && !byteIdx_r && bitCnt_r == BIT_HOLD_EXT && !engBusy) begin
            track_nxt  = 1'b0; // R06 R16
            engStart   = 1'b1;
            armExt_nxt = 1'b1; // R07
          end
          if (bitCnt_r == BIT_LAST) begin
            state_nxt = ST_RD_ACK;
          end
        end else if (sclFall && bitCnt_r != 4'h0) begin
          shift_nxt = {shift_r[6:0], 1'b0};
          sdaOe_nxt = !shift_r[6];
        end
        ST_RD_ACK: if (sclFall && bitCnt_r == BIT_ACK_DRIVE) begin
          sdaOe_nxt  = 1'b0;
          bitCnt_nxt = BIT_ACK_END;
        end else if (sclRise && bitCnt_r == BIT_ACK_END) begin
          bitCnt_nxt = BIT_ACK_DONE;
          if (sdaS) begin
            state_nxt = ST_IDLE; // Master refused more data.
          end
        end else if (sclFall && bitCnt_r == BIT_ACK_DONE) begin
          byteIdx_nxt = !byteIdx_r;
          shift_nxt   = nextRdByte;
          sdaOe_nxt   = !nextRdByte[7];
          bitCnt_nxt  = 4'h0;
          state_nxt   = ST_RD_BYTE;
        end
      endcase
    end
    // An externally clocked result returns the stage to tracking for the next pair.
    if (engDone && armExt_r) begin
      armExt_nxt = 1'b0;
      track_nxt  = 1'b1; // R16
    end
  end

  // Sequencer registers; bus pins only ever pull low.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_IDLE;
      bitCnt_r  <= 4'h0;
      shift_r   <= 8'h00;
      setup_r   <= SETUP_RST_VAL;
      cfg_r     <= CFG_RST_VAL;
      isRead_r  <= 1'b0;
      byteIdx_r <= 1'b0;
      sdaOe_r   <= 1'b0;
      sclOe_r   <= 1'b0;
      track_r   <= 1'b0;
      armExt_r  <= 1'b0;
      convInt_r <= 1'b0;
    end else if (clkEn) begin
      state_r   <= state_nxt;
      bitCnt_r  <= bitCnt_nxt;
      shift_r   <= shift_nxt;
      setup_r   <= setup_nxt;
      cfg_r     <= cfg_nxt;
      isRead_r  <= isRead_nxt;
      byteIdx_r <= byteIdx_nxt;
      sdaOe_r   <= sdaOe_nxt;
      sclOe_r   <= sclOe_nxt;
      track_r   <= track_nxt;
      armExt_r  <= armExt_nxt;
      convInt_r <= convInt_nxt;
    end
  end

  // Edge history and the internal conversion clock divider.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclPrev_r     <= 1'b1;
      sdaPrev_r     <= 1'b1;
      stepTglPrev_r <= 1'b0;
      divCnt_r      <= 16'h0000;
    end else if (clkEn) begin
      sclPrev_r     <= sclS;
      sdaPrev_r     <= sdaS;
      stepTglPrev_r <= stepTglS;
      divCnt_r      <= (!convInt_r || divWrap) ? 16'h0000 : divCnt_r + 16'h0001;
    end
  end

  // Registered outputs, so the analog switches never see decode glitches.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclOut         <= 1'b0;
      sclOe          <= 1'b0;
      sdaOut         <= 1'b0;
      sdaOe          <= 1'b0;
      dacCode        <= 10'h000;
      trackOn        <= 1'b0;
      muxPos         <= 4'h0;
      muxNeg         <= 4'h0;
      negToGnd       <= 1'b1;
      sharedPinIsRef <= 1'b0;
      convBusy       <= 1'b0;
      resultData     <= 10'h000;
      extClkMode     <= 1'b0;
      bipolar        <= 1'b0;
    end else if (clkEn) begin
      sclOe          <= sclOe_nxt; // R04
      sdaOe          <= sdaOe_nxt;
      dacCode        <= engCode;
      trackOn        <= track_nxt;
      muxPos         <= posSel; // R09 R10
      muxNeg         <= negSel; // R10
      negToGnd       <= singleEnded; // R09
      sharedPinIsRef <= setup_r[SETUP_SEL1]; // R11
      convBusy       <= engBusy;
      resultData     <= engDone ? engCode : resultData;
      extClkMode     <= useExt;
      bipolar        <= setup_r[SETUP_BIP_BIT] && !singleEnded;
    end
  end

endmodule

/* test/aths_sequencer_sva.sv */
// Assertions on the sequencer pins: track/hold timing, clock stretching and mux routing.
// Assumes clkEn stays high, so every counted cycle is a running cycle.
`timescale 1ns/1ps
module aths_sequencer_sva #(
  parameter int CONV_DIV = 100
) (
  // Clock and reset.
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // Bus pins.
  input wire logic       sclIn,
  input wire logic       sclOe,
  input wire logic       sdaOe,
  // Front end and status.
  input wire logic       trackOn,
  input wire logic [3:0] muxPos,
  input wire logic [3:0] muxNeg,
  input wire logic       negToGnd,
  input wire logic       convBusy,
  input wire logic       extClkMode
);
  logic [11:0] oeCnt_r;
  logic [11:0] busyCnt_r;

  // Run lengths of stretching and conversion; a plain repetition would be far too long.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oeCnt_r   <= 12'h000;
      busyCnt_r <= 12'h000;
    end else begin
      oeCnt_r   <= sclOe ? oeCnt_r + 12'h001 : 12'h000;
      busyCnt_r <= convBusy ? busyCnt_r + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Timing of the sample stage against bus edges and the conversion clock, then data edges and mux routing.
  a_conv_length: assert property (
    $fell(convBusy) && !extClkMode |-> busyCnt_r >= 10 * CONV_DIV - 2
      && busyCnt_r <= 10 * CONV_DIV + 8) else $error("conversion length off");
  a_stretch_bound: assert property (
    sclOe |-> oeCnt_r <= 10 * CONV_DIV + 16) else $error("stretch too long");
  a_stretch_in_hold: assert property (
    sclOe |-> !trackOn && !extClkMode) else $error("stretch outside internal hold");
  a_release_done: assert property (
    $fell(sclOe) |-> ##[0:4] !convBusy) else $error("clock released while busy");
  a_hold_busy: assert property (
    convBusy && !extClkMode |-> !trackOn) else $error("tracking during conversion");
  a_track_int_rise: assert property (
    $rose(trackOn) && !extClkMode |-> sclIn) else $error("track not on a rising edge");
  a_hold_int_fall: assert property (
    $fell(trackOn) && !extClkMode |-> !sclIn ##[0:2] sclOe) else $error("bad internal hold");
  a_hold_ext_rise: assert property (
    $fell(trackOn) && extClkMode |-> sclIn) else $error("external hold not on rise");
  a_sda_scl_low: assert property (
    $changed(sdaOe) && !$past(sclOe) && !$past(sclOe, 2) |-> !sclIn)
    else $error("data changed while clock high");
  a_mux_single: assert property (
    negToGnd |-> muxNeg == 4'h0) else $error("single-ended negative not grounded");
  a_mux_pair: assert property (
    !negToGnd |-> muxNeg == {muxPos[3:1], 1'b1} && !muxPos[0]) else $error("bad pair");

  // Main scenarios reached.
  c_stretch: cover property ($rose(sclOe));
  c_ext_hold: cover property ($fell(trackOn) && extClkMode);
  c_diff: cover property (!negToGnd);
endmodule

bind aths_sequencer aths_sequencer_sva #(.CONV_DIV(CONV_DIV)) aths_sequencer_sva_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .sclIn(sclIn), .sclOe(sclOe), .sdaOe(sdaOe),
  .trackOn(trackOn), .muxPos(muxPos), .muxNeg(muxNeg), .negToGnd(negToGnd),
  .convBusy(convBusy), .extClkMode(extClkMode));

/* test/aths_bus_master.sv */
// Behavioural two-wire bus master: frames, bytes and acknowledges on open-drain lines.
// Assumes pull-ups on both lines and a bit period of 48 ns; the clock is idle between frames.
`timescale 1ns/1ps
module aths_bus_master (
  // Line levels.
  input  wire logic sclLine,
  input  wire logic sdaLine,
  // Pull-down enables of this master.
  output logic      sclLow,
  output logic      sdaLow
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  // One bit: data moves only while the clock is low and is sampled mid-high.
  task automatic bitXfer(input logic bOut, output logic bIn);
    int n;
    #12 sdaLow = ~bOut;
    #12 sclLow = 1'b0;
    n = 0;
    while (sclLine !== 1'b1 && n < 4000) begin
      #2 n++;
    end
    #12 bIn = sdaLine;
    #12 sclLow = 1'b1;
  endtask

  task automatic busStart();
    #12 sdaLow = 1'b1;
    #12 sclLow = 1'b1;
  endtask

  task automatic busStop();
    #12 sdaLow = 1'b1;
    #12 sclLow = 1'b0;
    #12 sdaLow = 1'b0;
    #24;
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--) bitXfer(b[i], d);
    bitXfer(1'b1, d);
    ack = ~d;
  endtask

  // Clocks all bits whatever the slave does, so it can convert on them.
  task automatic recvByte(input logic giveAck, output logic [7:0] b);
    logic d;
    for (int i = 7; i >= 0; i--) bitXfer(1'b1, b[i]);
    bitXfer(~giveAck, d);
  endtask
endmodule

/* test/aths_sequencer_tb_top.sv */
// Testbench: bus master model, comparator model and checks of the sequencer pins.
// Assumes the sequencer answers ADDR and runs with a shortened conversion divider.
`timescale 1ns/1ps
module aths_sequencer_tb_top
  import aths_pkg::*;
();
  localparam logic [6:0] ADDR = 7'h55; // Arbitrary value.
  localparam int         DIV  = 8;
  logic       sys_clk, reset_n, clkEn, compHigh, sclLow, sdaLow, sclOe, sdaOe;
  logic       trackOn, negToGnd, extClkMode, bipolar, sharedPinIsRef, convBusy;
  logic [3:0] muxPos, muxNeg;
  logic [9:0] dacCode, resultData, vin;
  wire        sclLine, sdaLine;
  int         mismatches, checked, seed;

  // Open-drain lines with pull-ups.
  assign sclLine = ~(sclLow | sclOe);
  assign sdaLine = ~(sdaLow | sdaOe);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Ideal comparator: high while the input is at or above the trial code.
  always @(posedge sys_clk) compHigh <= (vin >= dacCode);

  aths_sequencer #(.DEV_ADDR(ADDR), .CONV_DIV(DIV)) aths_sequencer_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .sclClk(sclLine), .sclIn(sclLine),
    .sclOut(), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe),
    .compHigh(compHigh), .dacCode(dacCode), .trackOn(trackOn), .muxPos(muxPos),
    .muxNeg(muxNeg), .negToGnd(negToGnd), .sharedPinIsRef(sharedPinIsRef),
    .convBusy(convBusy), .resultData(resultData), .extClkMode(extClkMode), .bipolar(bipolar));

  aths_bus_master aths_bus_master_inst (
    .sclLine(sclLine), .sdaLine(sdaLine), .sclLow(sclLow), .sdaLow(sdaLow));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Expected {muxPos, muxNeg, negToGnd} for a configuration byte.
  function automatic logic [8:0] expMux(input logic [7:0] cfg);
    logic [3:0] cs;
    cs = cfg[CFG_CS_HI:CFG_CS_LO];
    if (cfg[CFG_PAIR_BIT]) return {cs, 4'h0, 1'b1};
    return {cs[3:1], 1'b0, cs[3:1], 1'b1, 1'b0};
  endfunction

  // Frames start off the clock edges so pin sampling never races the bench.
  task automatic openFrame(input logic [6:0] a, input logic rd, output logic ack);
    @(posedge sys_clk);
    #1;
    aths_bus_master_inst.busStart();
    aths_bus_master_inst.sendByte({a, rd}, ack);
  endtask

  task automatic writeBytes(input logic [7:0] b0, input logic [7:0] b1);
    logic ack;
    openFrame(ADDR, 1'b0, ack);
    check("write address ack", ack, 1'b1);
    aths_bus_master_inst.sendByte(b0, ack);
    aths_bus_master_inst.sendByte(b1, ack);
    check("data ack", ack, 1'b1);
    aths_bus_master_inst.busStop();
    repeat (8) @(posedge sys_clk);
  endtask

  // Reads one result pair; the master refuses the last byte to end the frame.
  task automatic readPair(output logic [15:0] pair);
    logic ack;
    openFrame(ADDR, 1'b1, ack);
    check("read address ack", ack, 1'b1);
    check("tracking after address", trackOn, 1'b1);
    #40;
    if (!extClkMode) check("stretch in hold", {sclOe, trackOn}, 2'b10);
    aths_bus_master_inst.recvByte(1'b1, pair[15:8]);
    aths_bus_master_inst.recvByte(1'b0, pair[7:0]);
    aths_bus_master_inst.busStop();
    repeat (8) @(posedge sys_clk);
  endtask

  initial begin
    logic [7:0]  cfgB, setB;
    logic [15:0] pair;
    logic [9:0]  prev;
    logic        ack;
    seed = 32'h3b5e_dd88;
    mismatches = 0;
    checked = 0;
    reset_n = 1'b0;
    clkEn = 1'b1;
    vin = 10'h000;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check("reset routing", {muxPos, muxNeg, negToGnd}, 9'h001);
    check("reset modes", {extClkMode, trackOn, sclOe}, 3'h0);
    openFrame(ADDR ^ 7'h01, 1'b0, ack);
    aths_bus_master_inst.busStop();
    check("foreign address ack", ack, 1'b0);
    // Setup and configuration in both orders, corners first.
    for (int k = 0; k < 8; k++) begin
      setB = {2'b10, 1'($random(seed)), 2'b00, 1'($random(seed)), 2'b10};
      cfgB = {3'b000, 4'($unsigned($random(seed)) % 12), 1'($random(seed))};
      if (k < 2) cfgB = k ? 8'h14 : 8'h17;
      if (k[0]) writeBytes(cfgB, setB);
      else writeBytes(setB, cfgB);
      check("mux routing", {muxPos, muxNeg, negToGnd}, expMux(cfgB));
      check("shared pin", sharedPinIsRef, setB[SETUP_SEL1]);
      check("bipolar", bipolar, setB[SETUP_BIP_BIT] & ~cfgB[CFG_PAIR_BIT]);
    end
    // Internally clocked conversions, full scale and zero first.
    for (int k = 0; k < 4; k++) begin
      vin <= (k == 0) ? 10'h3ff : (k == 1) ? 10'h000 : 10'($random(seed));
      readPair(pair);
      check("internal result", resultData, vin);
      check("internal bytes", pair, {RESULT_PAD, vin});
    end
    writeBytes(8'h8a, 8'h01);
    check("external mode", extClkMode, 1'b1);
    // Bus-clocked conversions: each frame shows the code of the one before.
    for (int k = 0; k < 3; k++) begin
      prev = vin;
      vin <= 10'($random(seed));
      readPair(pair);
      check("external bytes", pair, {RESULT_PAD, prev});
      check("external result", resultData, vin);
      check("track after conversion", trackOn, 1'b1);
    end
    give_verdict();
  end

  // Cuts a hang short well above the expected run of about 25 us.
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule
